// >>> dalu_defs.svh
// register map, field positions, condition bits, reset values and axi responses for the data alu slice
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef DALU_DEFS_SVH
`define DALU_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CMD      12'h000
`define OFS_IMM      12'h004
`define OFS_STATUS   12'h008
`define OFS_CCR      12'h00c
`define OFS_P0       12'h010
`define OFS_P1       12'h014
`define OFS_Q0       12'h018
`define OFS_Q1       12'h01c
`define OFS_ACC1_LO  12'h020
`define OFS_ACC1_HI  12'h024
`define OFS_ACC2_LO  12'h028
`define OFS_ACC2_HI  12'h02c
`define OFS_PTR      12'h030
`define OFS_OFF      12'h034
`define OFS_XBUS     12'h038
`define OFS_YBUS     12'h03c

// ---------------------------------------------------------------
// command word fields
// ---------------------------------------------------------------
`define CMD_OP_LSB    0
`define CMD_QQ_LSB    4
`define CMD_SSS_LSB   4
`define CMD_D_BIT     7
`define CMD_K_BIT     8
`define CMD_RND_BIT   9
`define CMD_MV_LSB    12
`define CMD_MDST_LSB  16
`define CMD_IMM8_LSB  24

// ---------------------------------------------------------------
// condition bits
// ---------------------------------------------------------------
`define CC_C 0
`define CC_V 1
`define CC_Z 2
`define CC_N 3
`define CC_U 4
`define CC_E 5
`define CC_L 6
`define CC_S 7

// ---------------------------------------------------------------
// reset values and axi responses
// ---------------------------------------------------------------
`define CCR_RESET   8'h00
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> dalu_pkg.sv
// types shared by the data alu slice and its testbench
// assumes dalu_defs.svh supplies the numeric constants
package dalu_pkg;

  // arithmetic portion of one instruction
  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_IMM_MAC_ROUND_OP     = 4'h1,
    OP_MAX       = 4'h2,
    OP_MAGNITUDE_TRANSFER_OP      = 4'h3,
    OP_MERGE     = 4'h4
  } alu_op_t;

  // parallel move categories (ten encodings)
  typedef enum logic [3:0] {
    MV_NONE  = 4'h0,
    MV_IMM   = 4'h1,
    MV_REG   = 4'h2,
    MV_UPD   = 4'h3,
    MV_X     = 4'h4,
    MV_XR    = 4'h5,
    MV_Y     = 4'h6,
    MV_RY    = 4'h7,
    MV_L     = 4'h8,
    MV_XY    = 4'h9
  } move_cat_t;

  // short move destinations
  typedef enum logic [3:0] {
    DST_P0 = 4'h0, DST_P1 = 4'h1, DST_Q0 = 4'h2, DST_Q1 = 4'h3,
    DST_A0 = 4'h4, DST_B0 = 4'h5, DST_A2 = 4'h6, DST_B2 = 4'h7,
    DST_A1 = 4'h8, DST_B1 = 4'h9, DST_A  = 4'ha, DST_B  = 4'hb,
    DST_R  = 4'hc, DST_N  = 4'hd
  } move_dst_t;

  // sequencer states, gray along idle-exec-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } seq_t;

endpackage : dalu_pkg

// >>> dalu_round.sv
// convergent or two's-complement rounding of a 40-bit accumulator at bit 16
// assumes pure combinational use inside the core clock domain
`timescale 1ns/1ns
module dalu_round (
  // operand
  input  wire logic [39:0] acc_in,
  input  wire logic        convergent,
  // result
  output logic      [39:0] acc_out
);

  logic [39:0] sum;      // value with half lsb added
  logic        tie;      // low part exactly one half

  // -------------------------------------------------------------
  // rounding
  // -------------------------------------------------------------
  always_comb
  begin
    sum = acc_in + 40'h00_0000_8000;
    tie = (acc_in[15:0] == 16'h8000);
    acc_out = {sum[39:16], 16'h0000};
    // convergent: ties go to even so repeated use stays unbiased
    if (convergent && tie)
    begin
      acc_out[16] = 1'b0;
    end
  end

endmodule : dalu_round

// >>> dalu_flags.sv
// standard condition bit computation for a 40-bit accumulator result
// assumes an eight-bit integer extension above a 32-bit fraction+word
`timescale 1ns/1ns
module dalu_flags (
  // result under test
  input  wire logic [39:0] res,
  input  wire logic        ovf,
  // derived flags
  output logic             f_e,
  output logic             f_u,
  output logic             f_n,
  output logic             f_z,
  output logic             f_s
);

  // -------------------------------------------------------------
  // flags
  // -------------------------------------------------------------
  always_comb
  begin
    // extension in use when bits 39..31 are not all equal
    f_e = !((res[39:31] == 9'h000) || (res[39:31] == 9'h1ff));
    f_u = (res[31] == res[30]);
    f_n = res[39];
    f_z = (res == 40'h00_0000_0000);
    // scaling bit: result already using bit 30 magnitude
    f_s = (res[31] != res[30]) | ovf;
  end

endmodule : dalu_flags

// >>> dalu_core.sv
// data alu slice: mac-round with immediate, conditional transfers, merge, moves
// assumes an axi4-lite master drives one command at a time; single clock domain
`timescale 1ns/1ns
`include "dalu_defs.svh"
module dalu_core (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import dalu_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] cmd_reg,  cmd_next;         // latched command word
  logic [15:0] imm_reg,  imm_next;         // long immediate extension word
  logic [7:0]  ccr_reg,  ccr_next;         // condition code register
  logic [15:0] inr_reg [4], inr_next [4];  // p0 p1 q0 q1
  logic [39:0] acc_reg [2], acc_next [2];  // first and second accumulator
  logic [15:0] ptr_reg,  ptr_next;         // pointer register target
  logic [15:0] off_reg,  off_next;         // offset register target
  logic [15:0] xbus_reg, xbus_next;        // last x bus word
  logic [15:0] ybus_reg, ybus_next;        // last y bus word
  logic [1:0]  xfer_reg, xfer_next;        // bus transfers of last executed command
  seq_t        st_reg,   st_next;          // sequencer
  logic        busy;                       // command in flight

  // bus slave state
  logic        aw_reg, aw_next;            // write address held
  logic        w_reg,  w_next;             // write data held
  logic [11:0] awa_reg, awa_next;
  logic [31:0] wd_reg,  wd_next;
  logic [3:0]  ws_reg,  ws_next;
  logic        bv_reg,  bv_next;
  logic [1:0]  br_reg,  br_next;
  logic        rv_reg,  rv_next;
  logic [31:0] rd_reg,  rd_next;
  logic [1:0]  rr_reg,  rr_next;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // merge of strobed bytes into a word
  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : strobe_merge

  // 40-bit magnitude, saturating is unneeded since 41-bit compare follows
  function automatic logic [40:0] mag40(input logic [39:0] v);
    // negative values are sign-extended before negation so the result is positive
    return v[39] ? (41'h0 - {v[39], v}) : {1'b0, v};
  endfunction : mag40

  // sign-extend a 16-bit operand into accumulator fraction position
  function automatic logic [39:0] sx16(input logic [15:0] v);
    return {{8{v[15]}}, v, 16'h0000};
  endfunction : sx16

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  alu_op_t     op;
  move_cat_t   mv;
  move_dst_t   mdst;
  logic        dsel, ksel, rconv;
  logic [1:0]  qq;
  logic [2:0]  join_src_field;
  logic [7:0]  imm8;
  always_comb
  begin
    op    = alu_op_t'(cmd_reg[`CMD_OP_LSB +: 4]);
    mv    = move_cat_t'(cmd_reg[`CMD_MV_LSB +: 4]);
    mdst  = move_dst_t'(cmd_reg[`CMD_MDST_LSB +: 4]);
    qq    = cmd_reg[`CMD_QQ_LSB +: 2];
    join_src_field   = cmd_reg[`CMD_SSS_LSB +: 3];
    dsel  = cmd_reg[`CMD_D_BIT];
    ksel  = cmd_reg[`CMD_K_BIT];
    rconv = !cmd_reg[`CMD_RND_BIT];
    imm8  = cmd_reg[`CMD_IMM8_LSB +: 8];
  end

  // ---------------------------------------------------------------
  // mac-round datapath
  // ---------------------------------------------------------------
  logic signed [31:0] prod;
  logic        [39:0] prod40, acc_sum, acc_rnd;
  logic               mac_ovf;
  logic [15:0]        qsrc;
  always_comb
  begin
    // qq order: p0, q0, p1, q1
    unique case (qq)
      2'd0: qsrc = inr_reg[0];
      2'd1: qsrc = inr_reg[2];
      2'd2: qsrc = inr_reg[1];
      default: qsrc = inr_reg[3];
    endcase
    prod   = $signed(imm_reg) * $signed(qsrc);
    // fractional product: shift left one and sign-extend to 40 bits
    prod40 = {{7{prod[31]}}, prod, 1'b0};
    if (ksel)
      prod40 = 40'h0 - prod40;
    acc_sum = acc_reg[dsel] + prod40;
    mac_ovf = (acc_reg[dsel][39] == prod40[39]) && (acc_sum[39] != prod40[39]);
  end

  dalu_round u_round (
    .acc_in     (acc_sum),
    .convergent (rconv),
    .acc_out    (acc_rnd)
  );

  logic f_e, f_u, f_n, f_z, f_s;
  dalu_flags u_flags (
    .res (acc_rnd),
    .ovf (mac_ovf),
    .f_e (f_e),
    .f_u (f_u),
    .f_n (f_n),
    .f_z (f_z),
    .f_s (f_s)
  );

  // ---------------------------------------------------------------
  // transfer compare and merge source
  // ---------------------------------------------------------------
  logic [40:0] sdiff, mdiff;
  logic        s_take, m_take;
  logic [15:0] msrc;
  logic [39:0] mres;
  always_comb
  begin
    sdiff  = {acc_reg[1][39], acc_reg[1]} - {acc_reg[0][39], acc_reg[0]};
    s_take = sdiff[40] || (sdiff == 41'h0);
    mdiff  = mag40(acc_reg[1]) - mag40(acc_reg[0]);
    m_take = mdiff[40] || (mdiff == 41'h0);
    unique case (join_src_field)
      3'd0: msrc = inr_reg[0];
      3'd1: msrc = inr_reg[1];
      3'd2: msrc = inr_reg[2];
      3'd3: msrc = inr_reg[3];
      3'd4: msrc = acc_reg[0][31:16];
      default: msrc = acc_reg[1][31:16];
    endcase
    mres = acc_reg[dsel];
    mres[31:16] = {msrc[7:0], acc_reg[dsel][23:16]};
  end

  // ---------------------------------------------------------------
  // execute: next values of the datapath registers
  // ---------------------------------------------------------------
  logic        exec;
  logic        acc_w;   // mac-round arithmetic writes acc_reg[dsel]
  always_comb
  begin
    exec = (st_reg == ST_EXEC);
    ccr_next = ccr_reg;
    for (int i = 0; i < 4; i++) inr_next[i] = inr_reg[i];
    for (int i = 0; i < 2; i++) acc_next[i] = acc_reg[i];
    ptr_next  = ptr_reg;
    off_next  = off_reg;
    xbus_next = xbus_reg;
    ybus_next = ybus_reg;
    xfer_next = xfer_reg;
    acc_w = 1'b0;
    if (exec)
    begin
      xfer_next = 2'b00;
      // parallel move portion first so that arithmetic overrides it
      unique case (mv)
        MV_NONE: ;
        MV_IMM:
        begin
          unique case (mdst)
            DST_P0, DST_P1, DST_Q0, DST_Q1:
              inr_next[mdst[1:0]] = {imm8, 8'h00};
            DST_A, DST_B:
              acc_next[mdst[0]] = {{8{imm8[7]}}, imm8, 24'h000000};
            DST_A0, DST_B0:
              acc_next[mdst[0]][15:0] = {8'h00, imm8};
            DST_A1, DST_B1:
              acc_next[mdst[0]][31:16] = {8'h00, imm8};
            DST_A2, DST_B2:
              acc_next[mdst[0]][39:32] = imm8;
            DST_R: ptr_next = {8'h00, imm8};
            DST_N: off_next = {8'h00, imm8};
            default: ;
          endcase
        end
        MV_XY, MV_L:
        begin
          // dual transfer: first input pair out on both buses
          xbus_next = inr_reg[0];
          ybus_next = inr_reg[2];
          xfer_next = 2'b11;
        end
        MV_X, MV_XR:
        begin
          xbus_next = acc_reg[0][31:16];
          xfer_next = 2'b01;
        end
        MV_Y, MV_RY:
        begin
          ybus_next = acc_reg[1][31:16];
          xfer_next = 2'b10;
        end
        default: ;
      endcase
      // arithmetic portion; duplicate destination resolved here
      unique case (op)
        OP_IMM_MAC_ROUND_OP:
        begin
          acc_next[dsel] = acc_rnd;
          acc_w = 1'b1;
          ccr_next[`CC_L] = ccr_reg[`CC_L] | mac_ovf;
          ccr_next[`CC_E] = f_e;
          ccr_next[`CC_U] = f_u;
          ccr_next[`CC_N] = f_n;
          ccr_next[`CC_Z] = f_z;
          ccr_next[`CC_V] = mac_ovf;
        end
        OP_MAX:
        begin
          if (s_take) acc_next[1] = acc_reg[0];
          ccr_next[`CC_C] = !s_take;
          ccr_next[`CC_L] = ccr_reg[`CC_L];
        end
        OP_MAGNITUDE_TRANSFER_OP:
        begin
          if (m_take) acc_next[1] = acc_reg[0];
          ccr_next[`CC_C] = !m_take;
          ccr_next[`CC_S] = ccr_reg[`CC_S] |
                            (acc_reg[0][31] != acc_reg[0][30]);
        end
        OP_MERGE:
        begin
          acc_next[dsel] = mres;
          ccr_next[`CC_N] = mres[31];
          ccr_next[`CC_Z] = (mres[31:16] == 16'h0000);
          ccr_next[`CC_V] = 1'b0;
        end
        default:
        begin
          // plain move: scaling tracks acc_reg[0] bits 31 and 30 whatever word moved, limit sticky
          if (mv != MV_NONE)
            ccr_next[`CC_S] = ccr_reg[`CC_S] | f_s & 1'b0 |
                              (acc_reg[0][31] != acc_reg[0][30]);
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sequencer: one command executes for one cycle after its write
  // ---------------------------------------------------------------
  logic wr_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      ST_IDLE: if (wr_fire && wr_addr == `OFS_CMD) st_next = ST_EXEC;
      ST_EXEC: st_next = ST_DONE;
      ST_DONE: st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
    busy = (st_reg != ST_IDLE);
  end

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  always_comb
  begin
    aw_next  = aw_reg;   awa_next = awa_reg;
    w_next   = w_reg;    wd_next  = wd_reg;   ws_next = ws_reg;
    bv_next  = bv_reg;   br_next  = br_reg;
    cmd_next = cmd_reg;  imm_next = imm_reg;
    s_axi_awready = !aw_reg && !bv_reg;
    s_axi_wready  = !w_reg && !bv_reg;
    if (s_axi_awvalid && s_axi_awready) begin aw_next = 1'b1; awa_next = s_axi_awaddr; end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_next = 1'b1; wd_next = s_axi_wdata; ws_next = s_axi_wstrb;
    end
    wr_fire = aw_reg && w_reg && !busy;
    wr_addr = {awa_reg[11:2], 2'b00};
    wr_data = wd_reg;
    if (wr_fire)
    begin
      aw_next = 1'b0;
      w_next  = 1'b0;
      bv_next = 1'b1;
      br_next = `RESP_OKAY;
      unique case (wr_addr)
        `OFS_CMD: cmd_next = strobe_merge(cmd_reg, wr_data, ws_reg);
        `OFS_IMM: imm_next = 16'(strobe_merge({16'h0, imm_reg}, wr_data, ws_reg));
        `OFS_CCR, `OFS_P0, `OFS_P1, `OFS_Q0, `OFS_Q1,
        `OFS_ACC1_LO, `OFS_ACC1_HI, `OFS_ACC2_LO, `OFS_ACC2_HI: ;
        default: br_next = `RESP_SLVERR;
      endcase
    end
    if (bv_reg && s_axi_bready) bv_next = 1'b0;
    s_axi_bvalid = bv_reg;
    s_axi_bresp  = br_reg;
  end

  // software loads of state registers (only when idle)
  logic [31:0] wv;
  always_comb
  begin
    wv = wr_data;
  end

  // ---------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------
  always_comb
  begin
    rv_next = rv_reg; rd_next = rd_reg; rr_next = rr_reg;
    s_axi_arready = !rv_reg;
    if (s_axi_arvalid && !rv_reg)
    begin
      rv_next = 1'b1;
      rr_next = `RESP_OKAY;
      unique case ({s_axi_araddr[11:2], 2'b00})
        `OFS_CMD:     rd_next = cmd_reg;
        `OFS_IMM:     rd_next = {16'h0, imm_reg};
        `OFS_STATUS:  rd_next = {28'h0, xfer_reg, st_reg};
        `OFS_CCR:     rd_next = {24'h0, ccr_reg};
        `OFS_P0:      rd_next = {16'h0, inr_reg[0]};
        `OFS_P1:      rd_next = {16'h0, inr_reg[1]};
        `OFS_Q0:      rd_next = {16'h0, inr_reg[2]};
        `OFS_Q1:      rd_next = {16'h0, inr_reg[3]};
        `OFS_ACC1_LO: rd_next = acc_reg[0][31:0];
        `OFS_ACC1_HI: rd_next = {24'h0, acc_reg[0][39:32]};
        `OFS_ACC2_LO: rd_next = acc_reg[1][31:0];
        `OFS_ACC2_HI: rd_next = {24'h0, acc_reg[1][39:32]};
        `OFS_PTR:     rd_next = {16'h0, ptr_reg};
        `OFS_OFF:     rd_next = {16'h0, off_reg};
        `OFS_XBUS:    rd_next = {16'h0, xbus_reg};
        `OFS_YBUS:    rd_next = {16'h0, ybus_reg};
        default:
        begin
          rd_next = 32'h0000_0000;
          rr_next = `RESP_SLVERR;
        end
      endcase
    end
    if (rv_reg && s_axi_rready) rv_next = 1'b0;
    s_axi_rvalid = rv_reg;
    s_axi_rdata  = rd_reg;
    s_axi_rresp  = rr_reg;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_reg <= 32'h0; imm_reg <= 16'h0; ccr_reg <= `CCR_RESET;
      for (int i = 0; i < 4; i++) inr_reg[i] <= 16'h0;
      for (int i = 0; i < 2; i++) acc_reg[i] <= 40'h0;
      ptr_reg <= 16'h0; off_reg <= 16'h0; xbus_reg <= 16'h0; ybus_reg <= 16'h0;
      xfer_reg <= 2'b00; st_reg <= ST_IDLE;
      aw_reg <= 1'b0; w_reg <= 1'b0; awa_reg <= 12'h0; wd_reg <= 32'h0; ws_reg <= 4'h0;
      bv_reg <= 1'b0; br_reg <= 2'b00; rv_reg <= 1'b0; rd_reg <= 32'h0; rr_reg <= 2'b00;
    end
    else
    begin
      cmd_reg <= cmd_next; imm_reg <= imm_next; ccr_reg <= ccr_next;
      for (int i = 0; i < 4; i++) inr_reg[i] <= inr_next[i];
      for (int i = 0; i < 2; i++) acc_reg[i] <= acc_next[i];
      // direct software loads while idle
      if (wr_fire)
      begin
        unique case (wr_addr)
          `OFS_CCR:     ccr_reg <= wv[7:0];
          `OFS_P0:      inr_reg[0] <= wv[15:0];
          `OFS_P1:      inr_reg[1] <= wv[15:0];
          `OFS_Q0:      inr_reg[2] <= wv[15:0];
          `OFS_Q1:      inr_reg[3] <= wv[15:0];
          `OFS_ACC1_LO: acc_reg[0][31:0] <= wv;
          `OFS_ACC1_HI: acc_reg[0][39:32] <= wv[7:0];
          `OFS_ACC2_LO: acc_reg[1][31:0] <= wv;
          `OFS_ACC2_HI: acc_reg[1][39:32] <= wv[7:0];
          default: ;
        endcase
      end
      ptr_reg <= ptr_next; off_reg <= off_next; xbus_reg <= xbus_next; ybus_reg <= ybus_next;
      xfer_reg <= xfer_next; st_reg <= st_next;
      aw_reg <= aw_next; w_reg <= w_next; awa_reg <= awa_next; wd_reg <= wd_next; ws_reg <= ws_next;
      bv_reg <= bv_next; br_reg <= br_next; rv_reg <= rv_next; rd_reg <= rd_next; rr_reg <= rr_next;
    end
  end

endmodule : dalu_core

// >>> axi_host_model.sv
// axi4-lite host stand-in driving the register bus of the alu slice
// assumes one write and one read task call at a time, same clock as the slice
`timescale 1ns/1ns
module axi_host_model (
  // slave answers
  input  wire logic        aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input  wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  input  wire logic [31:0] s_axi_rdata,
  // host requests
  output logic      [11:0] s_axi_awaddr, s_axi_araddr,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready
);
  // everything quiet at time zero, full word lanes always
  initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
           s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 65'hf;
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    fork
      begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      // released data shows the inverse so a late sample cannot pass
      begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; s_axi_wdata <= ~d; end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
endmodule : axi_host_model

// >>> dalu_core_asserts.sv
// bus handshake checks for the alu slice, bound onto its ports
// assumes single clock aclk and synchronous active-low aresetn
`timescale 1ns/1ns
module dalu_core_asserts (
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw taken early");
  w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:5] s_axi_bvalid) else $error("no write answer");
  r_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken early");
  c_err_c: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_wr_c: cover property (s_axi_bvalid && s_axi_bready);
  c_rd_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule : dalu_core_asserts
bind dalu_core dalu_core_asserts u_chk (.*);

// >>> dalu_core_tb.sv
// self-checking bench: integer model of the alu slice against the design
// assumes axi_host_model drives the register bus
`timescale 1ns/1ns
`include "dalu_defs.svh"
module dalu_core_tb;
  import dalu_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, k, cp;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures = 0, checked = 0, cyc = 0;
  longint a1 = 0, a2 = 0;          // model accumulators, sign carried above bit 39
  shortint imm, p0;
  logic [7:0] v;
  logic n = 0, z = 0, c = 0;       // model condition bits
  dalu_core dut (.*);
  axi_host_model m (.*);
  initial forever #10 aclk = ~aclk;
  // hang guard
  always @(posedge aclk) if (++cyc > 20000) begin failures++; summarize(); end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin failures++; $display("Error %s expected %h seen %h", s, e, g); end
  endtask : chk
  // issue a command, then poll until the sequencer is idle
  task automatic go(input logic [31:0] w);
    m.wr(`OFS_CMD, w, r);
    do m.rd(`OFS_STATUS, d, r); while (d[1:0] !== 2'b00);
  endtask : go
  task automatic summarize;
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial
  begin
    void'($urandom(62));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    m.rd(12'hffc, d, r);
    chk("unmapped", {30'h0, `RESP_SLVERR}, {30'h0, r});
    // short moves: r and n take the low byte, input registers p0 and q1 the top byte
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom;
      go({v, 4'h0, i == 0 ? DST_Q1 : i == 1 ? DST_R : i == 2 ? DST_N : DST_P0, MV_IMM, 12'h000});
      m.rd(i == 0 ? `OFS_Q1 : i == 1 ? `OFS_PTR : i == 2 ? `OFS_OFF : `OFS_P0, d, r);
      chk("move", (i == 1 || i == 2) ? {24'h0, v} : {16'h0, v, 8'h00}, {16'h0, d[15:0]});
    end
    p0 = {v, 8'h00};
    for (int j = 0; j < 4; j++)
    begin
      imm = $urandom;
      k = $urandom;
      m.wr(`OFS_IMM, {16'h0, imm}, r);
      // rounding alternates: the second pair of passes uses convergent mode
      go({22'h0, !j[1], k, 4'h0, OP_IMM_MAC_ROUND_OP});
      a1 = a1 + longint'(imm) * p0 * (k ? -2 : 2);
      cp = j[1] && ((a1 & 65535) == 32768);
      a1 = (a1 + 32768) & -65536;
      if (cp) a1 = a1 & ~longint'(65536);
      {n, z} = {a1 < 0, a1 == 0};
      m.rd(`OFS_ACC1_LO, d, r);
      chk("acc1", a1[31:0], d);
      m.rd(`OFS_CCR, d, r);
      chk("ccr", {28'h0, n, z, 1'b0, c}, d & 32'h0f);
      cp = j[0] ? (a1 < 0 ? -a1 : a1) >= (a2 < 0 ? -a2 : a2) : a1 >= a2;
      go(j[0] ? OP_MAGNITUDE_TRANSFER_OP : OP_MAX);
      if (cp) a2 = a1;
      c = !cp;
      m.rd(`OFS_ACC2_LO, d, r);
      chk("acc2", a2[31:0], d);
      m.rd(`OFS_CCR, d, r);
      chk("ccr", {28'h0, n, z, 1'b0, c}, d & 32'h0f);
    end
    // merge from the second accumulator's middle into the first
    go(32'h54);
    a1[31:24] = a2[23:16];
    {n, z} = {a1[31], a1[31:16] == 16'h0};
    m.rd(`OFS_ACC1_LO, d, r);
    chk("merge", a1[31:0], d);
    m.rd(`OFS_CCR, d, r);
    chk("ccr", {28'h0, n, z, 1'b0, c}, d & 32'h0f);
    summarize();
  end
endmodule : dalu_core_tb
